/* File: include/ptr_pkg.sv */
// Package with constants and types for the peripheral trigger routing fabric
package ptr_pkg;
   // Width of every trigger source select field
   localparam int SEL_W = 4;
   // Trigger source codes for timer and flexible-IO trigger select fields
   localparam logic [3:0] SRC_EXT_PIN = 4'h0;
   localparam logic [3:0] SRC_COMPARATOR = 4'h1;
   localparam logic [3:0] SRC_PIT_FLAG0 = 4'h4;
   localparam logic [3:0] SRC_PIT_FLAG1 = 4'h5;
   localparam logic [3:0] SRC_TIMER0_OVF = 4'h8;
   localparam logic [3:0] SRC_TIMER1_OVF = 4'h9;
   localparam logic [3:0] SRC_TIMER2_OVF = 4'hA;
   localparam logic [3:0] SRC_RTC_ALARM = 4'hC;
   localparam logic [3:0] SRC_RTC_SECONDS = 4'hD;
   localparam logic [3:0] SRC_LP_TIMER = 4'hE;
   // Converter trigger source codes, same encoding as above
   localparam logic [3:0] CONV_SRC_RESET = 4'h0;
   // Reset values of routed outputs
   localparam logic TRIG_RESET = 1'b0;
   localparam logic UART_IDLE = 1'b1;
   // Least spacing of converter triggers in stop modes, far side must honour it
   localparam int DUAL_TRIG_GAP_US = 10;
   localparam int CLK_MHZ = 100;
   localparam int DUAL_TRIG_GAP_CYC = DUAL_TRIG_GAP_US * CLK_MHZ;
   // Modulation source choices
   typedef enum logic {ptr_mod_timer1_type_val, ptr_mod_timer2_type_val} ptr_mod_src_type;
endpackage : ptr_pkg

/* File: hdl/ptr_source_mux.sv */
// Registered 4-bit trigger source selector shared by all trigger inputs
module ptr_source_mux (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Source choice
   input wire logic [3:0] select,
   // Candidate sources
   input wire logic ext_pin,
   input wire logic comparator,
   input wire logic pit_flag0,
   input wire logic pit_flag1,
   input wire logic [2:0] timer_ovf,
   input wire logic rtc_alarm,
   input wire logic rtc_seconds,
   input wire logic lp_timer,
   // Chosen trigger
   output logic trigger
);
   logic trig_reg;
   logic trig_next;

   // Decode the select field; unused codes give a quiet trigger
   always_comb begin
      case (select)
         ptr_pkg::SRC_EXT_PIN: trig_next = ext_pin;
         ptr_pkg::SRC_COMPARATOR: trig_next = comparator;
         ptr_pkg::SRC_PIT_FLAG0: trig_next = pit_flag0;
         ptr_pkg::SRC_PIT_FLAG1: trig_next = pit_flag1;
         ptr_pkg::SRC_TIMER0_OVF: trig_next = timer_ovf[0];
         ptr_pkg::SRC_TIMER1_OVF: trig_next = timer_ovf[1];
         ptr_pkg::SRC_TIMER2_OVF: trig_next = timer_ovf[2];
         ptr_pkg::SRC_RTC_ALARM: trig_next = rtc_alarm;
         ptr_pkg::SRC_RTC_SECONDS: trig_next = rtc_seconds;
         ptr_pkg::SRC_LP_TIMER: trig_next = lp_timer;
         default: trig_next = ptr_pkg::TRIG_RESET;
      endcase
   end

   // Register so the routed trigger comes straight from a flip-flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_reg <= ptr_pkg::TRIG_RESET;
      end else begin
         trig_reg <= trig_next;
      end
   end

   assign trigger = trig_reg;
endmodule : ptr_source_mux

/* File: hdl/ptr_routing.sv */
// Top of the peripheral trigger routing fabric
// Function
// - Alternate enable low: timer1 channel 0 to trigger A, channel 1 to B.
// - Low-power timer trigger goes to comparators for periodic low-power sampling.
// - Comparator feeds chosen UART receive; timer channel 0 modulates UART transmit.
// - Timeout flag 0 to DMA channel 0, flag 1 to channel 1, each enabled.
module ptr_routing #(
   parameter int NUM_TIMERS = 3,
   parameter int NUM_FLEX_TRIG = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Event sources
   input wire logic [2:0] counter_overflow_flag,
   input wire logic channel_zero_event_flag,
   input wire logic channel_one_event_flag,
   input wire logic periodic_timeout_flag_zero,
   input wire logic periodic_timeout_flag_one,
   input wire logic rtc_alarm_event,
   input wire logic rtc_seconds_event,
   input wire logic external_trigger_pin,
   input wire logic comparator_result_output,
   input wire logic low_power_trigger,
   // Timer channel 0 outputs used for infrared modulation
   input wire logic timer1_ch0_output,
   input wire logic timer2_ch0_output,
   // UART pins facing the outside
   input wire logic uart0_rx_pin,
   input wire logic uart1_rx_pin,
   input wire logic uart0_tx_raw,
   input wire logic uart1_tx_raw,
   // Converter trigger configuration
   input wire logic converter_alternate_trigger_enable,
   input wire logic [3:0] converter_trigger_source_select,
   input wire logic converter_pretrigger_ab_select,
   // Timer and flexible-IO trigger configuration
   input wire logic [NUM_TIMERS*4-1:0] trigger_source_field,
   input wire logic [NUM_FLEX_TRIG*4-1:0] flex_trigger_source_field,
   // Capture, UART and DMA configuration
   input wire logic timer1_capture_source_select,
   input wire logic timer2_capture_source_select,
   input wire logic uart0_receive_source_select,
   input wire logic uart1_receive_source_select,
   input wire logic uart0_transmit_modulation_select,
   input wire logic uart1_transmit_modulation_select,
   input wire logic [1:0] dma_request_enable,
   // Converter triggers
   output logic converter_trigger_a,
   output logic converter_trigger_b,
   // Comparator start trigger
   output logic comparator_start_trigger,
   // Timer trigger and capture inputs
   output logic [NUM_TIMERS-1:0] timer_trigger_input,
   output logic timer1_capture_input,
   output logic timer2_capture_input,
   // Flexible-IO trigger inputs
   output logic [NUM_FLEX_TRIG-1:0] flex_trigger_input,
   // UART paths
   output logic uart0_rx_routed,
   output logic uart1_rx_routed,
   output logic uart0_tx_pin,
   output logic uart1_tx_pin,
   // DMA hardware requests
   output logic [1:0] dma_hw_request
);
   // Parameter sanity: the timer overflow set is fixed at three
   if (NUM_TIMERS != 3) begin : g_bad_timers
      $error("NUM_TIMERS must be 3");
   end
   if (NUM_FLEX_TRIG < 1) begin : g_bad_flex
      $error("NUM_FLEX_TRIG must be at least 1");
   end

   // Shared decode of a 4-bit source code, used for the converter path
   function automatic logic pick_source(input logic [3:0] sel);
      case (sel)
         ptr_pkg::SRC_EXT_PIN: pick_source = external_trigger_pin;
         ptr_pkg::SRC_COMPARATOR: pick_source = comparator_result_output;
         ptr_pkg::SRC_PIT_FLAG0: pick_source = periodic_timeout_flag_zero;
         ptr_pkg::SRC_PIT_FLAG1: pick_source = periodic_timeout_flag_one;
         ptr_pkg::SRC_TIMER0_OVF: pick_source = counter_overflow_flag[0];
         ptr_pkg::SRC_TIMER1_OVF: pick_source = counter_overflow_flag[1];
         ptr_pkg::SRC_TIMER2_OVF: pick_source = counter_overflow_flag[2];
         ptr_pkg::SRC_RTC_ALARM: pick_source = rtc_alarm_event;
         ptr_pkg::SRC_RTC_SECONDS: pick_source = rtc_seconds_event;
         ptr_pkg::SRC_LP_TIMER: pick_source = low_power_trigger;
         default: pick_source = ptr_pkg::TRIG_RESET;
      endcase
   endfunction : pick_source

   // Timer trigger selectors; a timeout-flag source needs a fast timer clock
   for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer_trig
      ptr_source_mux u_mux (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .select(trigger_source_field[t*4 +: 4]),
         .ext_pin(external_trigger_pin),
         .comparator(comparator_result_output),
         .pit_flag0(periodic_timeout_flag_zero),
         .pit_flag1(periodic_timeout_flag_one),
         .timer_ovf(counter_overflow_flag),
         .rtc_alarm(rtc_alarm_event),
         .rtc_seconds(rtc_seconds_event),
         .lp_timer(low_power_trigger),
         .trigger(timer_trigger_input[t])
      );
   end

   // Flexible-IO trigger selectors; the one-cycle flags need a fast IO clock
   for (genvar f = 0; f < NUM_FLEX_TRIG; f++) begin : g_flex_trig
      ptr_source_mux u_mux (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .select(flex_trigger_source_field[f*4 +: 4]),
         .ext_pin(external_trigger_pin),
         .comparator(comparator_result_output),
         .pit_flag0(periodic_timeout_flag_zero),
         .pit_flag1(periodic_timeout_flag_one),
         .timer_ovf(counter_overflow_flag),
         .rtc_alarm(rtc_alarm_event),
         .rtc_seconds(rtc_seconds_event),
         .lp_timer(low_power_trigger),
         .trigger(flex_trigger_input[f])
      );
   end

   // Registered state for the fixed routes
   logic conv_a_reg, conv_a_next;
   logic conv_b_reg, conv_b_next;
   logic cmp_start_reg, cmp_start_next;
   logic cap1_reg, cap1_next;
   logic cap2_reg, cap2_next;
   logic rx0_reg, rx0_next;
   logic rx1_reg, rx1_next;
   logic tx0_reg, tx0_next;
   logic tx1_reg, tx1_next;
   logic [1:0] dma_reg, dma_next;
   logic conv_sel;

   // Next values of all fixed routes
   always_comb begin
      conv_sel = pick_source(converter_trigger_source_select);
      if (!converter_alternate_trigger_enable) begin
         // Dual-channel mode: stop-mode spacing is the far side's duty
         conv_a_next = channel_zero_event_flag;
         conv_b_next = channel_one_event_flag;
      end else begin
         // One source steered to A or B by the pretrigger select
         conv_a_next = conv_sel & ~converter_pretrigger_ab_select;
         conv_b_next = conv_sel & converter_pretrigger_ab_select;
      end
      cmp_start_next = low_power_trigger;
      cap1_next = timer1_capture_source_select ? comparator_result_output :
                                                 channel_zero_event_flag;
      cap2_next = timer2_capture_source_select ? comparator_result_output :
                                                 channel_zero_event_flag;
      rx0_next = uart0_receive_source_select ? comparator_result_output : uart0_rx_pin;
      rx1_next = uart1_receive_source_select ? comparator_result_output : uart1_rx_pin;
      // Modulation gates transmit low only while the chosen carrier is high
      tx0_next = uart0_tx_raw & ~(uart0_transmit_modulation_select ?
                                  timer2_ch0_output : timer1_ch0_output);
      tx1_next = uart1_tx_raw & ~(uart1_transmit_modulation_select ?
                                  timer2_ch0_output : timer1_ch0_output);
      dma_next = dma_request_enable &
                 {periodic_timeout_flag_one, periodic_timeout_flag_zero};
   end

   // One register stage keeps every output glitch free at one cycle of latency
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_a_reg <= ptr_pkg::TRIG_RESET;
         conv_b_reg <= ptr_pkg::TRIG_RESET;
         cmp_start_reg <= ptr_pkg::TRIG_RESET;
         cap1_reg <= ptr_pkg::TRIG_RESET;
         cap2_reg <= ptr_pkg::TRIG_RESET;
         rx0_reg <= ptr_pkg::UART_IDLE;
         rx1_reg <= ptr_pkg::UART_IDLE;
         tx0_reg <= ptr_pkg::UART_IDLE;
         tx1_reg <= ptr_pkg::UART_IDLE;
         dma_reg <= 2'h0;
      end else begin
         conv_a_reg <= conv_a_next;
         conv_b_reg <= conv_b_next;
         cmp_start_reg <= cmp_start_next;
         cap1_reg <= cap1_next;
         cap2_reg <= cap2_next;
         rx0_reg <= rx0_next;
         rx1_reg <= rx1_next;
         tx0_reg <= tx0_next;
         tx1_reg <= tx1_next;
         dma_reg <= dma_next;
      end
   end

   assign converter_trigger_a = conv_a_reg;
   assign converter_trigger_b = conv_b_reg;
   assign comparator_start_trigger = cmp_start_reg;
   assign timer1_capture_input = cap1_reg;
   assign timer2_capture_input = cap2_reg;
   assign uart0_rx_routed = rx0_reg;
   assign uart1_rx_routed = rx1_reg;
   assign uart0_tx_pin = tx0_reg;
   assign uart1_tx_pin = tx1_reg;
   assign dma_hw_request = dma_reg;
endmodule : ptr_routing

/* File: sim/ptr_peers.sv */
// Behavioural model of the second timer issuing paired converter trigger flags
module ptr_peers #(
   parameter int GAP = 1001
) (
   // Clock
   input wire logic sys_clk,
   // Request for one paired trigger
   input wire logic start,
   // Channel event flags
   output logic ch0_flag,
   output logic ch1_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      ch0_flag = 1'b0;
      ch1_flag = 1'b0;
   end
   // Sequence counter runs once per request, then idles at zero
   always @(posedge sys_clk) begin
      cnt <= ((start || cnt != 0) && cnt <= GAP) ? cnt + 1 : 0;
   end
   // Flags move off the sampling edge; B trails A by more than the stop-mode minimum
   always @(negedge sys_clk) begin
      ch0_flag <= (cnt == 1);
      ch1_flag <= (cnt == GAP + 1);
   end
endmodule : ptr_peers

/* File: sim/ptr_chk.sv */
// Concurrent checks on the ports of the trigger routing fabric
module ptr_chk #(
   parameter int NUM_TIMERS = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Sources and configuration
   input wire logic channel_zero_event_flag,
   input wire logic channel_one_event_flag,
   input wire logic periodic_timeout_flag_zero,
   input wire logic periodic_timeout_flag_one,
   input wire logic low_power_trigger,
   input wire logic converter_alternate_trigger_enable,
   input wire logic [NUM_TIMERS*4-1:0] trigger_source_field,
   input wire logic [1:0] dma_request_enable,
   // Routed outputs
   input wire logic converter_trigger_a,
   input wire logic converter_trigger_b,
   input wire logic comparator_start_trigger,
   input wire logic [NUM_TIMERS-1:0] timer_trigger_input,
   input wire logic [1:0] dma_hw_request
);
   default clocking dclk @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Pair mode; |=> skips the first edge, where the output still holds its reset value
   sequence s_pair;
      !converter_alternate_trigger_enable;
   endsequence
   a_pair_trig_a: assert property (s_pair |=>
      converter_trigger_a == $past(channel_zero_event_flag)) else $error("trigger A wrong");
   a_pair_trig_b: assert property (s_pair |=>
      converter_trigger_b == $past(channel_one_event_flag)) else $error("trigger B wrong");
   a_b_edge_follows: assert property (s_pair [*2] ##0 $rose(channel_one_event_flag) |=>
      $rose(converter_trigger_b)) else $error("trigger B edge lost");
   a_lp_to_cmp: assert property (1'b1 |=>
      comparator_start_trigger == $past(low_power_trigger)) else $error("cmp start wrong");
   a_lp_source: assert property (trigger_source_field[3:0] == 4'hE |=>
      timer_trigger_input[0] == $past(low_power_trigger)) else $error("lp source wrong");
   a_pit_source: assert property (trigger_source_field[7:4] == 4'h4 |=>
      timer_trigger_input[1] == $past(periodic_timeout_flag_zero)) else $error("pit source wrong");
   a_unused_code: assert property (trigger_source_field[11:8] == 4'h2 |=>
      !timer_trigger_input[2]) else $error("unused code drove trigger");
   a_dma_request: assert property (1'b1 |=> dma_hw_request == ($past(dma_request_enable) &
      {$past(periodic_timeout_flag_one), $past(periodic_timeout_flag_zero)}))
      else $error("dma request wrong");
endmodule : ptr_chk

bind ptr_routing ptr_chk #(.NUM_TIMERS(NUM_TIMERS)) i_chk (.*);

/* File: sim/tb.sv */
// Self-checking testbench for the trigger routing fabric
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = ptr_pkg::DUAL_TRIG_GAP_CYC + 1;
   localparam logic [3:0] CODES [10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8,
                                         4'h9, 4'hA, 4'hC, 4'hD, 4'hE};
   logic sys_clk, rst_n, start, ch0, ch1, alt, pre, c1s, c2s, t1c, t2c, rx0, rx1, tx0, tx1;
   logic u0r, u1r, u0t, u1t, ca, cb, cs, cap1, cap2, ur0, ur1, ut0, ut1;
   logic [9:0] src;
   logic [3:0] csel, fti;
   logic [11:0] tsel;
   logic [15:0] fsel, na, nb;
   logic [1:0] den, dma, p;
   logic [2:0] tti;
   int failures = 0;
   int n_tests = 0;
   ptr_routing i_dut (.sys_clk, .rst_n, .counter_overflow_flag(src[6:4]),
      .channel_zero_event_flag(ch0), .channel_one_event_flag(ch1),
      .periodic_timeout_flag_zero(src[2]), .periodic_timeout_flag_one(src[3]),
      .rtc_alarm_event(src[7]), .rtc_seconds_event(src[8]), .external_trigger_pin(src[0]),
      .comparator_result_output(src[1]), .low_power_trigger(src[9]),
      .timer1_ch0_output(t1c), .timer2_ch0_output(t2c), .uart0_rx_pin(rx0),
      .uart1_rx_pin(rx1), .uart0_tx_raw(tx0), .uart1_tx_raw(tx1),
      .converter_alternate_trigger_enable(alt), .converter_trigger_source_select(csel),
      .converter_pretrigger_ab_select(pre), .trigger_source_field(tsel),
      .flex_trigger_source_field(fsel), .timer1_capture_source_select(c1s),
      .timer2_capture_source_select(c2s), .uart0_receive_source_select(u0r),
      .uart1_receive_source_select(u1r), .uart0_transmit_modulation_select(u0t),
      .uart1_transmit_modulation_select(u1t), .dma_request_enable(den),
      .converter_trigger_a(ca), .converter_trigger_b(cb), .comparator_start_trigger(cs),
      .timer_trigger_input(tti), .timer1_capture_input(cap1), .timer2_capture_input(cap2),
      .flex_trigger_input(fti), .uart0_rx_routed(ur0), .uart1_rx_routed(ur1),
      .uart0_tx_pin(ut0), .uart1_tx_pin(ut1), .dma_hw_request(dma));
   ptr_peers #(.GAP(GAP)) i_peer (.sys_clk, .start, .ch0_flag(ch0), .ch1_flag(ch1));
   // Bus clock, 100 MHz
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Inputs change on the falling edge; one rising edge later the output must follow
   task automatic tick;
      @(negedge sys_clk);
   endtask : tick
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // Watchdog; the run needs about 11 us
   initial begin
      #100us;
      failures++;
      end_of_test();
   end
   // Main sequence
   initial begin
      {src, csel, tsel, fsel, den, start, alt, pre, c1s, c2s, t1c, t2c} = '0;
      {rx0, rx1, tx0, tx1, u0r, u1r, u0t, u1t, na, nb} = '0;
      rst_n = 1'b0;
      repeat (16) tick();
      chk({ca, cb, cs, ut0, ur0}, 5'h03);
      rst_n = 1'b1;
      // Every source code, alone high and alone low, on all trigger inputs
      // Routed triggers are looked at every bus cycle, as a fast timer or IO clock would
      for (int i = 0; i < 10; i++) begin
         tsel = {3{CODES[i]}};
         fsel = {4{CODES[i]}};
         src = 10'h001 << i;
         tick();
         chk({tti, fti}, 7'h7F);
         src = ~(10'h001 << i);
         tick();
         chk({tti, fti}, 7'h00);
      end
      // Unused code with every source high must stay quiet
      tsel = 12'h222;
      src = 10'h3FF;
      tick();
      chk({tti, cs}, 4'h1);
      // Receive, modulation and DMA paths, both selections each
      src = 10'h006;
      {den, u0r, u1r, u0t, u1t, c1s, c2s, t1c, tx0, tx1} = 11'h2B7;
      tick();
      chk({dma, ur0, ur1, ut0, ut1, cap1, cap2, cs}, 9'h0AC);
      src = 10'h00A;
      rx1 = 1'b1;
      {den, u0r, u1r, u0t, u1t, c1s, c2s, t1c, tx0, tx1} = 11'h74F;
      tick();
      chk({dma, ur0, ur1, ut0, ut1, cap1, cap2, cs}, 9'h172);
      // Comparator low and both pins high, so each receive select is told apart
      rx0 = 1'b1;
      src = 10'h000;
      tick();
      chk({ur0, ur1}, 2'h1);
      // Alternate converter path steered to A, then to B
      alt = 1'b1;
      csel = 4'hE;
      src = 10'h200;
      tick();
      chk({ca, cb}, 2'b10);
      pre = 1'b1;
      tick();
      chk({ca, cb}, 2'b01);
      // Every converter source code, steered to A or B by the pretrigger select
      for (int i = 0; i < 10; i++) begin
         csel = CODES[i];
         pre = i[0];
         src = 10'h001 << i;
         tick();
         chk({ca, cb}, i[0] ? 2'h1 : 2'h2);
         src = ~(10'h001 << i);
         tick();
         chk({ca, cb}, 2'h0);
      end
      alt = 1'b0;
      // Paired triggering: each flag reaches its own trigger exactly once
      start = 1'b1;
      tick();
      start = 1'b0;
      for (int j = 0; j < GAP + 4; j++) begin
         @(posedge sys_clk);
         p = {ch0, ch1};
         tick();
         chk({ca, cb}, p);
         na = na + 16'(ca);
         nb = nb + 16'(cb);
      end
      chk(na, 16'h0001);
      chk(nb, 16'h0001);
      end_of_test();
   end
endmodule : tb
